// ---- design/pieb_pkg.sv ----
package pieb_pkg;

  localparam int PIEB_DATA_W = 8;
  localparam int PIEB_ADDR_W = 4;
  localparam int PIEB_NUM_EN = 5;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_CLK_CONV_EN = 4'h0;
  localparam logic [3:0] OFS_ZC_CMP_EN = 4'h1;
  localparam logic [3:0] OFS_SERIAL_EN = 4'h2;
  localparam logic [3:0] OFS_TIMER_EN = 4'h3;
  localparam logic [3:0] OFS_CELL_GATE_EN = 4'h4;
  localparam logic [3:0] OFS_IRQ_CONTROL = 4'h5;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
  localparam logic [3:0] OFS_PENDING = 4'h8;
  localparam logic [3:0] OFS_FLAG_FIRST = 4'h9;
  localparam logic [3:0] OFS_FLAG_LAST = 4'hD;

  // bank indices
  localparam int IDX_CLK_CONV = 0;
  localparam int IDX_ZC_CMP = 1;
  localparam int IDX_SERIAL = 2;
  localparam int IDX_TIMER = 3;
  localparam int IDX_CELL_GATE = 4;

  // field positions
  localparam int OSC_FAIL_BIT = 7;
  localparam int CLK_SWITCH_BIT = 6;
  localparam int CONV_THRESHOLD_BIT = 1;
  localparam int CONV_DONE_BIT = 0;
  localparam int ZERO_CROSS_BIT = 6;
  localparam int CMP_TWO_BIT = 1;
  localparam int CMP_ONE_BIT = 0;
  localparam int ASYNC_RX_BIT = 5;
  localparam int ASYNC_TX_BIT = 4;
  localparam int PORT_TWO_COLL_BIT = 3;
  localparam int PORT_TWO_EVT_BIT = 2;
  localparam int PORT_ONE_COLL_BIT = 1;
  localparam int PORT_ONE_EVT_BIT = 0;
  localparam int TIMER_SIX_BIT = 5;
  localparam int TIMER_FIVE_BIT = 4;
  localparam int TIMER_FOUR_BIT = 3;
  localparam int TIMER_THREE_BIT = 2;
  localparam int TIMER_TWO_BIT = 1;
  localparam int TIMER_ONE_BIT = 0;
  localparam int CELL_FOUR_BIT = 7;
  localparam int CELL_THREE_BIT = 6;
  localparam int CELL_TWO_BIT = 5;
  localparam int CELL_ONE_BIT = 4;
  localparam int GATE_FIVE_BIT = 2;
  localparam int GATE_THREE_BIT = 1;
  localparam int GATE_ONE_BIT = 0;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int ST_REQ_RISE_BIT = 0;
  localparam int ST_BLOCKED_BIT = 1;
  localparam int ST_CPU_RISE_BIT = 2;

  // implemented bits; the rest ignore writes and read as zero
  localparam logic [7:0] MASK_CLK_CONV = 8'hC3;
  localparam logic [7:0] MASK_ZC_CMP = 8'h43;
  localparam logic [7:0] MASK_SERIAL = 8'h3F;
  localparam logic [7:0] MASK_TIMER = 8'h3F;
  localparam logic [7:0] MASK_CELL_GATE = 8'hF7;
  localparam logic [7:0] MASK_CONTROL = 8'hC0;
  localparam logic [7:0] MASK_STATUS = 8'h07;

  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [7:0] RESET_MASK = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [PIEB_ADDR_W-1:0] addr;
    logic [PIEB_DATA_W-1:0] wdata;
  } pieb_bus_req_t;

  typedef logic [PIEB_NUM_EN-1:0][PIEB_DATA_W-1:0] pieb_bank_t;

  function automatic logic [7:0] pieb_impl_mask(input logic [2:0] idx);
    case (idx)
      3'h0: pieb_impl_mask = MASK_CLK_CONV;
      3'h1: pieb_impl_mask = MASK_ZC_CMP;
      3'h2: pieb_impl_mask = MASK_SERIAL;
      3'h3: pieb_impl_mask = MASK_TIMER;
      3'h4: pieb_impl_mask = MASK_CELL_GATE;
      default: pieb_impl_mask = 8'h00;
    endcase
  endfunction

endpackage

// ---- design/pieb_enable_bank.sv ----
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module pieb_enable_bank
  import pieb_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire pieb_bus_req_t bus_i,
  output logic [PIEB_DATA_W-1:0] rd_data_o,
  input wire pieb_bank_t src_flag_i,
  output logic periph_req_o,
  output logic cpu_irq_req_o,
  output logic irq_o
);

  pieb_bank_t en_bank;
  pieb_bank_t next_en_bank;
  logic [7:0] irq_ctrl;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic blocked;

  // address decode
  wire en_addr = (bus_i.addr <= OFS_CELL_GATE_EN);
  wire flag_addr = (bus_i.addr >= OFS_FLAG_FIRST) && (bus_i.addr <= OFS_FLAG_LAST);
  wire [2:0] en_idx = bus_i.addr[2:0];
  wire [3:0] flag_off = bus_i.addr - OFS_FLAG_FIRST;
  wire [2:0] flag_idx = flag_off[2:0];
  wire wr_ctrl = bus_i.wr && (bus_i.addr == OFS_IRQ_CONTROL);
  wire wr_mask = bus_i.wr && (bus_i.addr == OFS_IRQ_MASK);
  wire rd_status = bus_i.rd && (bus_i.addr == OFS_IRQ_STATUS);

  // named enable fields
  wire osc_fail_irq_en = en_bank[IDX_CLK_CONV][OSC_FAIL_BIT];
  wire clk_switch_done_irq_en = en_bank[IDX_CLK_CONV][CLK_SWITCH_BIT];
  wire conv_threshold_irq_en = en_bank[IDX_CLK_CONV][CONV_THRESHOLD_BIT];
  wire conv_done_irq_en = en_bank[IDX_CLK_CONV][CONV_DONE_BIT];
  wire zero_cross_irq_en = en_bank[IDX_ZC_CMP][ZERO_CROSS_BIT];
  wire comparator_two_irq_en = en_bank[IDX_ZC_CMP][CMP_TWO_BIT];
  wire comparator_one_irq_en = en_bank[IDX_ZC_CMP][CMP_ONE_BIT];
  wire async_rx_irq_en = en_bank[IDX_SERIAL][ASYNC_RX_BIT];
  wire async_tx_irq_en = en_bank[IDX_SERIAL][ASYNC_TX_BIT];
  wire port_two_collision_irq_en = en_bank[IDX_SERIAL][PORT_TWO_COLL_BIT];
  wire port_two_event_irq_en = en_bank[IDX_SERIAL][PORT_TWO_EVT_BIT];
  wire port_one_collision_irq_en = en_bank[IDX_SERIAL][PORT_ONE_COLL_BIT];
  wire port_one_event_irq_en = en_bank[IDX_SERIAL][PORT_ONE_EVT_BIT];
  wire timer_six_match_irq_en = en_bank[IDX_TIMER][TIMER_SIX_BIT];
  wire timer_five_ovf_irq_en = en_bank[IDX_TIMER][TIMER_FIVE_BIT];
  wire timer_four_match_irq_en = en_bank[IDX_TIMER][TIMER_FOUR_BIT];
  wire timer_three_ovf_irq_en = en_bank[IDX_TIMER][TIMER_THREE_BIT];
  wire timer_two_match_irq_en = en_bank[IDX_TIMER][TIMER_TWO_BIT];
  wire timer_one_ovf_irq_en = en_bank[IDX_TIMER][TIMER_ONE_BIT];
  wire logic_cell_four_irq_en = en_bank[IDX_CELL_GATE][CELL_FOUR_BIT];
  wire logic_cell_three_irq_en = en_bank[IDX_CELL_GATE][CELL_THREE_BIT];
  wire logic_cell_two_irq_en = en_bank[IDX_CELL_GATE][CELL_TWO_BIT];
  wire logic_cell_one_irq_en = en_bank[IDX_CELL_GATE][CELL_ONE_BIT];
  wire timer_five_gate_irq_en = en_bank[IDX_CELL_GATE][GATE_FIVE_BIT];
  wire timer_three_gate_irq_en = en_bank[IDX_CELL_GATE][GATE_THREE_BIT];
  wire timer_one_gate_irq_en = en_bank[IDX_CELL_GATE][GATE_ONE_BIT];
  wire global_irq_en = irq_ctrl[GLOBAL_EN_BIT];
  wire periph_irq_master_en = irq_ctrl[PERIPH_EN_BIT];

  // writes keep only implemented bits
  for (genvar g = 0; g < PIEB_NUM_EN; g++) begin : g_en
    wire hit = bus_i.wr && (bus_i.addr == 4'(g));
    assign next_en_bank[g] = hit ? (bus_i.wdata & pieb_impl_mask(3'(g))) : en_bank[g];
  end

  // flags are never altered here, only qualified
  pieb_bank_t gated;
  logic [PIEB_NUM_EN-1:0] pending;
  for (genvar g = 0; g < PIEB_NUM_EN; g++) begin : g_gate
    assign gated[g] = src_flag_i[g] & en_bank[g];
    assign pending[g] = |gated[g];
  end

  wire any_pending = |pending;
  wire next_periph_req = any_pending && periph_irq_master_en;
  wire next_cpu_req = next_periph_req && global_irq_en;
  wire next_blocked = any_pending && !next_cpu_req;

  // events for the block's own status register
  logic [7:0] events;
  assign events = 8'((next_periph_req && !periph_req_o) << ST_REQ_RISE_BIT)
                | 8'((next_blocked && !blocked) << ST_BLOCKED_BIT)
                | 8'((next_cpu_req && !cpu_irq_req_o) << ST_CPU_RISE_BIT);
  // set wins over the read clear so no edge is lost
  wire [7:0] next_status = ((rd_status ? 8'h00 : irq_status) | events) & MASK_STATUS;
  wire next_irq = |(next_status & irq_mask);

  // read selection
  wire [7:0] rd_en_val = en_bank[en_idx] & pieb_impl_mask(en_idx);
  wire [7:0] rd_flag_val = src_flag_i[flag_idx];
  wire [7:0] rd_sel = en_addr ? rd_en_val :
                      flag_addr ? rd_flag_val :
                      (bus_i.addr == OFS_IRQ_CONTROL) ? irq_ctrl :
                      (bus_i.addr == OFS_IRQ_STATUS) ? irq_status :
                      (bus_i.addr == OFS_IRQ_MASK) ? irq_mask :
                      (bus_i.addr == OFS_PENDING) ? 8'(pending) : 8'h00;
  wire [7:0] next_rd_data = bus_i.rd ? rd_sel : 8'h00;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_bank <= {PIEB_NUM_EN{RESET_ENABLE}};
      irq_ctrl <= RESET_CONTROL;
      irq_mask <= RESET_MASK;
      irq_status <= RESET_STATUS;
    end else begin
      en_bank <= next_en_bank;
      irq_status <= next_status;
      if (wr_ctrl) begin
        irq_ctrl <= bus_i.wdata & MASK_CONTROL;
      end
      if (wr_mask) begin
        irq_mask <= bus_i.wdata & MASK_STATUS;
      end
    end
  end

  // outputs registered; one cycle from flag to request
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_req_o <= 1'b0;
      cpu_irq_req_o <= 1'b0;
      blocked <= 1'b0;
      irq_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      periph_req_o <= next_periph_req;
      cpu_irq_req_o <= next_cpu_req;
      blocked <= next_blocked;
      irq_o <= next_irq;
      rd_data_o <= next_rd_data;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_osc_fail_path: assert property (
    src_flag_i[IDX_CLK_CONV][OSC_FAIL_BIT] && osc_fail_irq_en && periph_irq_master_en |=> periph_req_o)
    else $error("oscillator failure did not raise request");

  a_clk_switch_path: assert property (
    src_flag_i[IDX_CLK_CONV][CLK_SWITCH_BIT] && clk_switch_done_irq_en && periph_irq_master_en |=> periph_req_o)
    else $error("clock switch done did not raise request");

  a_converter_paths: assert property (
    ((src_flag_i[IDX_CLK_CONV][CONV_THRESHOLD_BIT] && conv_threshold_irq_en)
     || (src_flag_i[IDX_CLK_CONV][CONV_DONE_BIT] && conv_done_irq_en)) && periph_irq_master_en
    |=> periph_req_o)
    else $error("converter source did not raise request");

  a_reserved_zero: assert property (
    (en_bank[IDX_CLK_CONV] & ~MASK_CLK_CONV) == 8'h00 && (en_bank[IDX_ZC_CMP] & ~MASK_ZC_CMP) == 8'h00
    && (en_bank[IDX_SERIAL] & ~MASK_SERIAL) == 8'h00 && (en_bank[IDX_TIMER] & ~MASK_TIMER) == 8'h00
    && (en_bank[IDX_CELL_GATE] & ~MASK_CELL_GATE) == 8'h00)
    else $error("unimplemented enable bit is set");

  a_reserved_read: assert property (
    bus_i.rd && bus_i.addr == OFS_CLK_CONV_EN |=> (rd_data_o & ~MASK_CLK_CONV) == 8'h00)
    else $error("unimplemented bit read as one");

  a_zero_cross_path: assert property (
    src_flag_i[IDX_ZC_CMP][ZERO_CROSS_BIT] && zero_cross_irq_en && periph_irq_master_en |=> periph_req_o)
    else $error("zero cross did not raise request");

  a_comparator_paths: assert property (
    ((src_flag_i[IDX_ZC_CMP][CMP_TWO_BIT] && comparator_two_irq_en)
     || (src_flag_i[IDX_ZC_CMP][CMP_ONE_BIT] && comparator_one_irq_en)) && periph_irq_master_en
    |=> periph_req_o)
    else $error("comparator did not raise request");

  a_master_gate: assert property (
    !periph_irq_master_en |=> !periph_req_o && !cpu_irq_req_o)
    else $error("request passed with peripheral enable clear");

  a_serial_paths: assert property (
    ((src_flag_i[IDX_SERIAL][ASYNC_RX_BIT] && async_rx_irq_en)
     || (src_flag_i[IDX_SERIAL][ASYNC_TX_BIT] && async_tx_irq_en)) && periph_irq_master_en
    |=> periph_req_o)
    else $error("serial source did not raise request");

  a_port_paths: assert property (
    ((src_flag_i[IDX_SERIAL][PORT_TWO_COLL_BIT] && port_two_collision_irq_en)
     || (src_flag_i[IDX_SERIAL][PORT_TWO_EVT_BIT] && port_two_event_irq_en)
     || (src_flag_i[IDX_SERIAL][PORT_ONE_COLL_BIT] && port_one_collision_irq_en)
     || (src_flag_i[IDX_SERIAL][PORT_ONE_EVT_BIT] && port_one_event_irq_en)) && periph_irq_master_en
    |=> periph_req_o)
    else $error("port source did not raise request");

  a_timer_match: assert property (
    ((src_flag_i[IDX_TIMER][TIMER_SIX_BIT] && timer_six_match_irq_en)
     || (src_flag_i[IDX_TIMER][TIMER_FOUR_BIT] && timer_four_match_irq_en)
     || (src_flag_i[IDX_TIMER][TIMER_TWO_BIT] && timer_two_match_irq_en)) && periph_irq_master_en
    |=> periph_req_o)
    else $error("timer match did not raise request");

  a_timer_overflow: assert property (
    ((src_flag_i[IDX_TIMER][TIMER_FIVE_BIT] && timer_five_ovf_irq_en)
     || (src_flag_i[IDX_TIMER][TIMER_THREE_BIT] && timer_three_ovf_irq_en)
     || (src_flag_i[IDX_TIMER][TIMER_ONE_BIT] && timer_one_ovf_irq_en)) && periph_irq_master_en
    |=> periph_req_o)
    else $error("timer overflow did not raise request");

  a_cell_paths: assert property (
    ((src_flag_i[IDX_CELL_GATE][CELL_FOUR_BIT] && logic_cell_four_irq_en)
     || (src_flag_i[IDX_CELL_GATE][CELL_THREE_BIT] && logic_cell_three_irq_en)
     || (src_flag_i[IDX_CELL_GATE][CELL_TWO_BIT] && logic_cell_two_irq_en)
     || (src_flag_i[IDX_CELL_GATE][CELL_ONE_BIT] && logic_cell_one_irq_en)) && periph_irq_master_en
    |=> periph_req_o)
    else $error("logic cell did not raise request");

  a_gate_paths: assert property (
    ((src_flag_i[IDX_CELL_GATE][GATE_FIVE_BIT] && timer_five_gate_irq_en)
     || (src_flag_i[IDX_CELL_GATE][GATE_THREE_BIT] && timer_three_gate_irq_en)
     || (src_flag_i[IDX_CELL_GATE][GATE_ONE_BIT] && timer_one_gate_irq_en)) && periph_irq_master_en
    |=> periph_req_o)
    else $error("gate acquisition did not raise request");

  a_write_readback: assert property (
    bus_i.wr && bus_i.addr == OFS_TIMER_EN ##1 !bus_i.wr ##1 bus_i.rd && bus_i.addr == OFS_TIMER_EN && !bus_i.wr
    |=> rd_data_o == ($past(bus_i.wdata, 3) & MASK_TIMER))
    else $error("enable write not read back");

  a_write_clk_conv: assert property (
    bus_i.wr && bus_i.addr == OFS_CLK_CONV_EN
    |=> en_bank[IDX_CLK_CONV] == ($past(bus_i.wdata) & MASK_CLK_CONV))
    else $error("first enable write lost");

  a_write_zc_cmp: assert property (
    bus_i.wr && bus_i.addr == OFS_ZC_CMP_EN
    |=> en_bank[IDX_ZC_CMP] == ($past(bus_i.wdata) & MASK_ZC_CMP))
    else $error("second enable write lost");

  a_write_serial: assert property (
    bus_i.wr && bus_i.addr == OFS_SERIAL_EN
    |=> en_bank[IDX_SERIAL] == ($past(bus_i.wdata) & MASK_SERIAL))
    else $error("third enable write lost");

  a_write_timer: assert property (
    bus_i.wr && bus_i.addr == OFS_TIMER_EN
    |=> en_bank[IDX_TIMER] == ($past(bus_i.wdata) & MASK_TIMER))
    else $error("fourth enable write lost");

  a_write_cell_gate: assert property (
    bus_i.wr && bus_i.addr == OFS_CELL_GATE_EN
    |=> en_bank[IDX_CELL_GATE] == ($past(bus_i.wdata) & MASK_CELL_GATE))
    else $error("fifth enable write lost");

  a_hold_clk_conv: assert property (
    !(bus_i.wr && bus_i.addr == OFS_CLK_CONV_EN)
    |=> $stable(en_bank[IDX_CLK_CONV]))
    else $error("first enable changed without write");

  a_hold_zc_cmp: assert property (
    !(bus_i.wr && bus_i.addr == OFS_ZC_CMP_EN)
    |=> $stable(en_bank[IDX_ZC_CMP]))
    else $error("second enable changed without write");

  a_hold_serial: assert property (
    !(bus_i.wr && bus_i.addr == OFS_SERIAL_EN)
    |=> $stable(en_bank[IDX_SERIAL]))
    else $error("third enable changed without write");

  a_hold_timer: assert property (
    !(bus_i.wr && bus_i.addr == OFS_TIMER_EN)
    |=> $stable(en_bank[IDX_TIMER]))
    else $error("fourth enable changed without write");

  a_hold_cell_gate: assert property (
    !(bus_i.wr && bus_i.addr == OFS_CELL_GATE_EN)
    |=> $stable(en_bank[IDX_CELL_GATE]))
    else $error("fifth enable changed without write");

  a_read_clk_conv: assert property (
    bus_i.rd && bus_i.addr == OFS_CLK_CONV_EN
    |=> rd_data_o == $past(en_bank[IDX_CLK_CONV]))
    else $error("first enable read wrong");

  a_read_zc_cmp: assert property (
    bus_i.rd && bus_i.addr == OFS_ZC_CMP_EN
    |=> rd_data_o == $past(en_bank[IDX_ZC_CMP]))
    else $error("second enable read wrong");

  a_read_serial: assert property (
    bus_i.rd && bus_i.addr == OFS_SERIAL_EN
    |=> rd_data_o == $past(en_bank[IDX_SERIAL]))
    else $error("third enable read wrong");

  a_read_timer: assert property (
    bus_i.rd && bus_i.addr == OFS_TIMER_EN
    |=> rd_data_o == $past(en_bank[IDX_TIMER]))
    else $error("fourth enable read wrong");

  a_read_cell_gate: assert property (
    bus_i.rd && bus_i.addr == OFS_CELL_GATE_EN
    |=> rd_data_o == $past(en_bank[IDX_CELL_GATE]))
    else $error("fifth enable read wrong");

  a_flag_view_two: assert property (
    bus_i.rd && bus_i.addr == OFS_FLAG_FIRST + 4'h1
    |=> rd_data_o == $past(src_flag_i[IDX_ZC_CMP]))
    else $error("second flag view wrong");

  a_flag_view_three: assert property (
    bus_i.rd && bus_i.addr == OFS_FLAG_FIRST + 4'h2
    |=> rd_data_o == $past(src_flag_i[IDX_SERIAL]))
    else $error("third flag view wrong");

  a_flag_view_four: assert property (
    bus_i.rd && bus_i.addr == OFS_FLAG_FIRST + 4'h3
    |=> rd_data_o == $past(src_flag_i[IDX_TIMER]))
    else $error("fourth flag view wrong");

  a_flag_view_five: assert property (
    bus_i.rd && bus_i.addr == OFS_FLAG_LAST
    |=> rd_data_o == $past(src_flag_i[IDX_CELL_GATE]))
    else $error("fifth flag view wrong");

  a_control_write: assert property (
    wr_ctrl
    |=> irq_ctrl == ($past(bus_i.wdata) & MASK_CONTROL))
    else $error("control write lost");

  a_control_read: assert property (
    bus_i.rd && bus_i.addr == OFS_IRQ_CONTROL
    |=> (rd_data_o & ~MASK_CONTROL) == 8'h00)
    else $error("control unused bit read as one");

  a_read_idle_zero: assert property (
    !bus_i.rd
    |=> rd_data_o == 8'h00)
    else $error("read data not zero when idle");

  a_global_block: assert property (
    !global_irq_en
    |=> !cpu_irq_req_o)
    else $error("cpu request with global enable clear");

  a_enabled_raises: assert property (
    any_pending && periph_irq_master_en
    |=> periph_req_o)
    else $error("enabled flag did not raise request");

  a_irq_level: assert property (
    irq_o
    |-> (irq_status & $past(irq_mask)) != 8'h00)
    else $error("interrupt without unmasked status");

  a_read_clears: assert property (
    rd_status && events == 8'h00
    |=> irq_status == 8'h00)
    else $error("status not cleared by read");

  a_disabled_blocks: assert property (
    ((src_flag_i & en_bank) == '0) |=> !periph_req_o)
    else $error("request without an enabled flag");

  a_flag_visible: assert property (
    bus_i.rd && bus_i.addr == OFS_FLAG_FIRST |=> rd_data_o == $past(src_flag_i[IDX_CLK_CONV]))
    else $error("flag view differs from source flags");

  a_global_gate: assert property (
    cpu_irq_req_o |-> $past(global_irq_en) && periph_req_o)
    else $error("cpu request without global enable");

  a_request_or: assert property (
    ##1 periph_req_o == ($past(any_pending) && $past(periph_irq_master_en)))
    else $error("peripheral request not the gated OR");

  c_request_rise: cover property (!periph_req_o ##1 periph_req_o);
  c_cpu_request: cover property (periph_req_o && global_irq_en ##1 cpu_irq_req_o);
  c_blocked_flag: cover property (any_pending && !periph_irq_master_en);
  c_status_irq: cover property (!irq_o ##1 irq_o ##[1:20] !irq_o);
  c_read_clear: cover property (rd_status ##1 irq_status == 8'h00);

endmodule

// ---- tb/pieb_src_model.sv ----
`timescale 1ns/10ps
module pieb_src_model
  import pieb_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire pieb_bank_t pattern_i,
  output pieb_bank_t src_flag_o
);
  // flags are held levels; a source never waits for its enable to raise one
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_flag_o <= '0;
    end else if (load_i) begin
      src_flag_o <= pattern_i;
    end
  end
endmodule

// ---- tb/peripheral_interrupt_enable_bank_test.sv ----
`timescale 1ns/10ps
module peripheral_interrupt_enable_bank_test;
  import pieb_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  pieb_bus_req_t bus = '0;
  logic load = 1'b0;
  pieb_bank_t pattern = '0;
  pieb_bank_t flags;
  pieb_bank_t pat_m = '0;
  logic [7:0] rd_data;
  logic periph_req;
  logic cpu_req;
  logic irq;
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h51c0d37f;
  logic [7:0] impl [5] = '{8'hC3, 8'h43, 8'h3F, 8'h3F, 8'hF7};
  logic [7:0] en_m [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ctl_m = 8'h00;
  logic [7:0] got;

  always #20 ref_clk_i = ~ref_clk_i;

  pieb_src_model src (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .load_i(load), .pattern_i(pattern),
    .src_flag_o(flags));
  pieb_enable_bank uut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus_i(bus), .rd_data_o(rd_data),
    .src_flag_i(flags), .periph_req_o(periph_req), .cpu_irq_req_o(cpu_req), .irq_o(irq));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one idle cycle between accesses keeps each strobe a single assignment per edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    bus <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    bus <= '0;
    #1 d = rd_data;
  endtask

  task automatic wr_m(input logic [3:0] a, input logic [7:0] d);
    wr(a, d);
    if (a < 4'h5) en_m[a] = d & impl[a];
    if (a == 4'h5) ctl_m = d & 8'hC0;
  endtask

  task automatic set_flags(input pieb_bank_t p);
    @(posedge ref_clk_i);
    pat_m = p;
    pattern <= p;
    load <= 1'b1;
    @(posedge ref_clk_i);
    load <= 1'b0;
  endtask

  task automatic check_req();
    logic e;
    e = 1'b0;
    @(posedge ref_clk_i);
    #1;
    for (int i = 0; i < 5; i++) e |= |(pat_m[i] & en_m[i]);
    e &= ctl_m[6];
    chk("periph request", {7'h00, periph_req}, {7'h00, e});
    chk("cpu request", {7'h00, cpu_req}, {7'h00, e & ctl_m[7]});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_reset_values();
    for (int i = 0; i < 6; i++) begin
      rd(i[3:0], got);
      chk("reset value", got, 8'h00);
    end
  endtask

  initial begin
    #400000;
    mismatches++;
    results();
  end

  initial begin
    pieb_bank_t p;
    int fi;
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    check_reset_values();
    rd(4'hE, got);
    chk("unmapped read", got, 8'h00);
    for (int i = 0; i < 5; i++) begin
      for (int b = 0; b < 8; b++) begin
        wr_m(i[3:0], 8'h01 << b);
        rd(i[3:0], got);
        chk("enable bit", got, (8'h01 << b) & impl[i]);
      end
      wr_m(i[3:0], 8'hFF);
      rd(i[3:0], got);
      chk("enable all", got, impl[i]);
    end
    @(posedge ref_clk_i);
    #1 chk("read data idle", rd_data, 8'h00);
    // single flags against full enables, gated by each control setting
    for (int c = 0; c < 4; c++) begin
      wr_m(4'h5, c[1:0] << 6);
      for (int n = 0; n < 40; n += (c == 3) ? 1 : 7) begin
        p = '0;
        p[n / 8][n % 8] = 1'b1;
        set_flags(p);
        check_req();
      end
    end
    // random enables, control and flags
    for (int k = 0; k < 60; k++) begin
      wr_m(4'({$random(seed)} % 6), 8'($random(seed)));
      for (int i = 0; i < 5; i++) p[i] = 8'($random(seed));
      set_flags(p);
      check_req();
      fi = {$random(seed)} % 5;
      rd(4'h9 + 4'(fi), got);
      chk("flag view", got, pat_m[fi]);
    end
    for (int i = 0; i < 5; i++) begin
      rd(4'h9 + i[3:0], got);
      chk("flag view", got, pat_m[i]);
    end
    // sticky status, mask and read-clear
    set_flags('0);
    for (int i = 0; i < 5; i++) wr_m(i[3:0], 8'h00);
    wr_m(4'h5, 8'h40);
    wr(4'h7, 8'h01);
    rd(4'h6, got);
    chk("irq idle", {7'h00, irq}, 8'h00);
    wr_m(4'h0, 8'h80);
    p = '0;
    p[0][7] = 1'b1;
    set_flags(p);
    check_req();
    @(posedge ref_clk_i);
    #1 chk("irq raised", {7'h00, irq}, 8'h01);
    wr(4'h6, 8'h00);
    rd(4'h6, got);
    chk("status periph rise", got & 8'h05, 8'h01);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    wr(4'h7, 8'h00);
    wr_m(4'h5, 8'hC0);
    check_req();
    @(posedge ref_clk_i);
    #1 chk("irq masked", {7'h00, irq}, 8'h00);
    rd(4'h6, got);
    chk("status cpu rise", got & 8'h05, 8'h04);
    // reset in mid-run clears every enable
    for (int i = 0; i < 5; i++) wr_m(i[3:0], 8'hFF);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) en_m[i] = 8'h00;
    ctl_m = 8'h00;
    pat_m = '0;
    check_reset_values();
    check_req();
    results();
  end
endmodule
